// >>> hw/fb_config_check.v
// Combinational checker of the feedback divide setting held in the register bank.
// Assumes its inputs come from registers; its outputs are registered by the caller.
`timescale 1ns/1ns
`include "pll_fb_defs.vh"

module fb_config_check (
	input wire [9:0] divHigh,
	input wire [31:0] denominator,
	input wire [31:0] remainder,
	input wire [7:0] truncPos,
	output reg [5:0] validFracBits,
	output reg fractionalMode,
	output reg denZeroErr,
	output reg truncRangeErr,
	output reg intModeErr,
	output reg truncBitErr,
	output reg intZeroErr
);

	always @* begin
		// Valid fractional bits are 33 minus the truncate position, or zero when the position is above 33
		if (truncPos > `FB_TRUNC_MAX) begin
			validFracBits = 6'h00;
		end else begin
			validFracBits = `FB_FRAC_BITS - truncPos[5:0];
		end
		// Truncation only matters in the divisor plus remainder over denominator form
		fractionalMode = (remainder != 32'h00000000) || (truncPos != 8'h00);
		denZeroErr = (denominator == 32'h00000000);
		truncRangeErr = (truncPos > `FB_TRUNC_MAX);
		intModeErr = (truncPos == 8'h00) &&
			((remainder != 32'h00000000) || (denominator != `FB_DEN_ONE));
		// Only fractional bit 32 lives in this bank; position 33 requires it clear
		truncBitErr = (truncPos == `FB_TRUNC_MAX) && divHigh[`FB_LOW_FRAC_POS];
		// Integer part sits entirely in bits 41:33
		intZeroErr = (divHigh[9:1] == 9'h000);
	end

endmodule // fb_config_check

// >>> hw/pll_feedback_divider_regs.v
// Byte-wide register bank holding the upper divisor bytes, denominator, remainder and
// truncate position of the PLL fractional feedback divider, plus registered setting checks.
// Assumes a synchronous byte register port driven by the host interface on the same clock.
//
// Behaviour
// - Divisor bits 39:32 held in fifth byte.
// - Divisor bits 41:40 in sixth byte bits 1:0.
// - Denominator assembled from four bytes, LSB lowest.
// - Remainder assembled from four bytes, LSB lowest.
// - Valid fractional bits equal 33 minus position, or zero for positions above 33.
// - Truncation applies only in fractional remainder form.
// - Divisor is 9 integer, 33 fractional bits.
`timescale 1ns/1ns
`include "pll_fb_defs.vh"

module pll_feedback_divider_regs (
	input wire clock,
	input wire rst_n,
	input wire [9:0] regAddr,
	input wire regWrEn,
	input wire [7:0] regWrData,
	input wire regRdEn,
	output reg [7:0] regRdData,
	output reg regRdValid,
	output reg regAddrErr,
	output wire [9:0] fixedDivisorHigh,
	output wire [31:0] feedbackDenominator,
	output wire [31:0] feedbackRemainder,
	output wire [7:0] fractionTruncatePosition,
	output reg [5:0] validFracBits,
	output reg fractionalMode,
	output reg denZeroErr,
	output reg truncRangeErr,
	output reg intModeErr,
	output reg truncBitErr,
	output reg intZeroErr
);

	// One-hot select of the byte register at an offset; all zero outside the bank
	function [10:0] regSelect;
		input [9:0] addr;
		begin
			regSelect = 11'h000;
			case (addr)
				`FB_DIV_B4_ADDR: begin
					regSelect = 11'h001;
				end
				`FB_DIV_B5_ADDR: begin
					regSelect = 11'h002;
				end
				`FB_DEN_B0_ADDR: begin
					regSelect = 11'h004;
				end
				`FB_DEN_B1_ADDR: begin
					regSelect = 11'h008;
				end
				`FB_DEN_B2_ADDR: begin
					regSelect = 11'h010;
				end
				`FB_DEN_B3_ADDR: begin
					regSelect = 11'h020;
				end
				`FB_REM_B0_ADDR: begin
					regSelect = 11'h040;
				end
				`FB_REM_B1_ADDR: begin
					regSelect = 11'h080;
				end
				`FB_REM_B2_ADDR: begin
					regSelect = 11'h100;
				end
				`FB_REM_B3_ADDR: begin
					regSelect = 11'h200;
				end
				`FB_TRUNC_ADDR: begin
					regSelect = 11'h400;
				end
				default: begin
					regSelect = 11'h000;
				end
			endcase
		end
	endfunction

	// True when the offset falls inside this bank
	function inBank;
		input [9:0] addr;
		begin
			inBank = (regSelect(addr) != 11'h000);
		end
	endfunction

	reg [7:0] divB4_ff;
	reg [1:0] divB5_ff;
	reg [7:0] denB0_ff;
	reg [7:0] denB1_ff;
	reg [7:0] denB2_ff;
	reg [7:0] denB3_ff;
	reg [7:0] remB0_ff;
	reg [7:0] remB1_ff;
	reg [7:0] remB2_ff;
	reg [7:0] remB3_ff;
	reg [7:0] truncPos_ff;
	reg [7:0] nxt_divB4;
	reg [1:0] nxt_divB5;
	reg [7:0] nxt_denB0;
	reg [7:0] nxt_denB1;
	reg [7:0] nxt_denB2;
	reg [7:0] nxt_denB3;
	reg [7:0] nxt_remB0;
	reg [7:0] nxt_remB1;
	reg [7:0] nxt_remB2;
	reg [7:0] nxt_remB3;
	reg [7:0] nxt_truncPos;
	reg [7:0] nxt_rdData;
	wire [10:0] wrSel;
	localparam [7:0] DIV_B5_RST_FULL = `FB_DIV_B5_RST & `FB_DIV_B5_MASK;
	wire [5:0] chkValidFracBits;
	wire chkFractionalMode;
	wire chkDenZeroErr;
	wire chkTruncRangeErr;
	wire chkIntModeErr;
	wire chkTruncBitErr;
	wire chkIntZeroErr;

	// Write strobe decoded to one register; unmapped offsets select nothing
	assign wrSel = regWrEn ? regSelect(regAddr) : 11'h000;

	// Next register values: a write replaces one byte and every other register holds
	always @* begin
		nxt_divB4 = divB4_ff;
		nxt_divB5 = divB5_ff;
		nxt_denB0 = denB0_ff;
		nxt_denB1 = denB1_ff;
		nxt_denB2 = denB2_ff;
		nxt_denB3 = denB3_ff;
		nxt_remB0 = remB0_ff;
		nxt_remB1 = remB1_ff;
		nxt_remB2 = remB2_ff;
		nxt_remB3 = remB3_ff;
		nxt_truncPos = truncPos_ff;
		if (wrSel[0]) begin
			nxt_divB4 = regWrData;
		end
		if (wrSel[1]) begin
			nxt_divB5 = regWrData[1:0];
		end
		if (wrSel[2]) begin
			nxt_denB0 = regWrData;
		end
		if (wrSel[3]) begin
			nxt_denB1 = regWrData;
		end
		if (wrSel[4]) begin
			nxt_denB2 = regWrData;
		end
		if (wrSel[5]) begin
			nxt_denB3 = regWrData;
		end
		if (wrSel[6]) begin
			nxt_remB0 = regWrData;
		end
		if (wrSel[7]) begin
			nxt_remB1 = regWrData;
		end
		if (wrSel[8]) begin
			nxt_remB2 = regWrData;
		end
		if (wrSel[9]) begin
			nxt_remB3 = regWrData;
		end
		if (wrSel[10]) begin
			nxt_truncPos = regWrData;
		end
	end

	// Register storage; illegal settings are kept as written and only flagged
	always @(posedge clock) begin
		if (!rst_n) begin
			divB4_ff <= `FB_DIV_B4_RST;
			divB5_ff <= DIV_B5_RST_FULL[1:0];
			denB0_ff <= `FB_DEN_B0_RST;
			denB1_ff <= `FB_DEN_BX_RST;
			denB2_ff <= `FB_DEN_BX_RST;
			denB3_ff <= `FB_DEN_BX_RST;
			remB0_ff <= `FB_REM_BX_RST;
			remB1_ff <= `FB_REM_BX_RST;
			remB2_ff <= `FB_REM_BX_RST;
			remB3_ff <= `FB_REM_BX_RST;
			truncPos_ff <= `FB_TRUNC_RST;
		end else begin
			divB4_ff <= nxt_divB4;
			divB5_ff <= nxt_divB5;
			denB0_ff <= nxt_denB0;
			denB1_ff <= nxt_denB1;
			denB2_ff <= nxt_denB2;
			denB3_ff <= nxt_denB3;
			remB0_ff <= nxt_remB0;
			remB1_ff <= nxt_remB1;
			remB2_ff <= nxt_remB2;
			remB3_ff <= nxt_remB3;
			truncPos_ff <= nxt_truncPos;
		end
	end

	// Read multiplexer
	always @* begin
		nxt_rdData = 8'h00;
		case (regAddr)
			`FB_DIV_B4_ADDR: begin
				nxt_rdData = divB4_ff;
			end
			`FB_DIV_B5_ADDR: begin
				nxt_rdData = {6'h00, divB5_ff};
			end
			`FB_DEN_B0_ADDR: begin
				nxt_rdData = denB0_ff;
			end
			`FB_DEN_B1_ADDR: begin
				nxt_rdData = denB1_ff;
			end
			`FB_DEN_B2_ADDR: begin
				nxt_rdData = denB2_ff;
			end
			`FB_DEN_B3_ADDR: begin
				nxt_rdData = denB3_ff;
			end
			`FB_REM_B0_ADDR: begin
				nxt_rdData = remB0_ff;
			end
			`FB_REM_B1_ADDR: begin
				nxt_rdData = remB1_ff;
			end
			`FB_REM_B2_ADDR: begin
				nxt_rdData = remB2_ff;
			end
			`FB_REM_B3_ADDR: begin
				nxt_rdData = remB3_ff;
			end
			`FB_TRUNC_ADDR: begin
				nxt_rdData = truncPos_ff;
			end
			default: begin
				nxt_rdData = 8'h00;
			end
		endcase
	end

	// Read data answers one cycle after the strobe; unmapped offsets read zero
	always @(posedge clock) begin
		if (!rst_n) begin
			regRdData <= 8'h00;
			regRdValid <= 1'b0;
			regAddrErr <= 1'b0;
		end else begin
			regRdValid <= regRdEn;
			if (regRdEn) begin
				regRdData <= nxt_rdData;
			end
			regAddrErr <= (regRdEn || regWrEn) && !inBank(regAddr);
		end
	end

	// Field assembly toward the analog PLL core
	assign fixedDivisorHigh = {divB5_ff, divB4_ff};
	assign feedbackDenominator = {denB3_ff, denB2_ff, denB1_ff, denB0_ff};
	assign feedbackRemainder = {remB3_ff, remB2_ff, remB1_ff, remB0_ff};
	assign fractionTruncatePosition = truncPos_ff;

	fb_config_check fb_config_check_i (
		.divHigh(fixedDivisorHigh),
		.denominator(feedbackDenominator),
		.remainder(feedbackRemainder),
		.truncPos(truncPos_ff),
		.validFracBits(chkValidFracBits),
		.fractionalMode(chkFractionalMode),
		.denZeroErr(chkDenZeroErr),
		.truncRangeErr(chkTruncRangeErr),
		.intModeErr(chkIntModeErr),
		.truncBitErr(chkTruncBitErr),
		.intZeroErr(chkIntZeroErr)
	);

	// Setting checks lag the registers by one cycle
	always @(posedge clock) begin
		if (!rst_n) begin
			validFracBits <= `FB_FRAC_BITS;
			fractionalMode <= 1'b0;
			denZeroErr <= 1'b0;
			truncRangeErr <= 1'b0;
			intModeErr <= 1'b0;
			truncBitErr <= 1'b0;
			intZeroErr <= 1'b1;
		end else begin
			validFracBits <= chkValidFracBits;
			fractionalMode <= chkFractionalMode;
			denZeroErr <= chkDenZeroErr;
			truncRangeErr <= chkTruncRangeErr;
			intModeErr <= chkIntModeErr;
			truncBitErr <= chkTruncBitErr;
			intZeroErr <= chkIntZeroErr;
		end
	end

endmodule // pll_feedback_divider_regs

// >>> inc/pll_fb_defs.vh
// Offsets, field positions, reset values and limits of the PLL feedback divider register bank.
// Included by the bank and by its configuration checker; holds definitions only.
`ifndef PLL_FB_DEFS_VH
`define PLL_FB_DEFS_VH

// Byte register offsets on the host register port
`define FB_ADDR_W 10
`define FB_DIV_B4_ADDR 10'h10a
`define FB_DIV_B5_ADDR 10'h10b
`define FB_DEN_B0_ADDR 10'h10c
`define FB_DEN_B1_ADDR 10'h10d
`define FB_DEN_B2_ADDR 10'h10e
`define FB_DEN_B3_ADDR 10'h10f
`define FB_REM_B0_ADDR 10'h110
`define FB_REM_B1_ADDR 10'h111
`define FB_REM_B2_ADDR 10'h112
`define FB_REM_B3_ADDR 10'h113
`define FB_TRUNC_ADDR 10'h114
`define FB_FIRST_ADDR 10'h10a
`define FB_LAST_ADDR 10'h114

// Reset values
`define FB_DIV_B4_RST 8'h00
`define FB_DIV_B5_RST 8'h00
`define FB_DEN_B0_RST 8'h01
`define FB_DEN_BX_RST 8'h00
`define FB_REM_BX_RST 8'h00
`define FB_TRUNC_RST 8'h00

// Field layout
`define FB_DIV_B5_MASK 8'h03
`define FB_DIV_B5_BITS 2
`define FB_DIV_HIGH_W 10
`define FB_INT_BITS 9
`define FB_FRAC_BITS 6'h21
`define FB_FRAC_BITS_W 6
`define FB_TRUNC_MAX 8'h21
`define FB_DEN_ONE 32'h00000001
`define FB_LOW_FRAC_POS 0

`endif

// >>> tb/pll_fb_regs_monitor.sv
// Assertion checker for the feedback divider register bank.
// Bound to the bank's top module and sees only its ports.
`timescale 1ns/1ns
module pll_fb_regs_monitor (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [9:0] regAddr,
	input wire logic regWrEn,
	input wire logic [7:0] regWrData,
	input wire logic regRdEn,
	input wire logic [7:0] regRdData,
	input wire logic regRdValid,
	input wire logic regAddrErr,
	input wire logic [9:0] fixedDivisorHigh,
	input wire logic [31:0] feedbackDenominator,
	input wire logic [31:0] feedbackRemainder,
	input wire logic [7:0] fractionTruncatePosition,
	input wire logic [5:0] validFracBits,
	input wire logic denZeroErr,
	input wire logic intModeErr
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	rd_valid_a: assert property (regRdValid == $past(regRdEn))
		else $error("read valid does not follow read strobe");
	div_low_a: assert property (regWrEn && regAddr == 10'h10a |=>
		fixedDivisorHigh[7:0] == $past(regWrData)) else $error("divisor byte four not taken");
	div_top_a: assert property (regWrEn && regAddr == 10'h10b |=>
		{6'h00, fixedDivisorHigh[9:8]} == ($past(regWrData) & 8'h03))
		else $error("divisor top bits not taken");
	spare_zero_a: assert property (regRdEn && regAddr == 10'h10b |=>
		regRdData[7:2] == 6'h00) else $error("spare divisor bits read nonzero");
	den_top_a: assert property (regWrEn && regAddr == 10'h10f |=>
		feedbackDenominator[31:24] == $past(regWrData)) else $error("denominator top byte wrong");
	rem_low_a: assert property (regWrEn && regAddr == 10'h110 |=>
		feedbackRemainder[7:0] == $past(regWrData)) else $error("remainder low byte wrong");
	valid_bits_a: assert property (fractionTruncatePosition <= 8'h21 |=>
		{2'b00, validFracBits} == 8'h21 - $past(fractionTruncatePosition))
		else $error("valid fraction bit count wrong");
	den_zero_a: assert property (feedbackDenominator == 32'h0 |=> denZeroErr)
		else $error("zero denominator not flagged");
	int_mode_a: assert property (fractionTruncatePosition == 8'h00 &&
		(feedbackRemainder != 32'h0 || feedbackDenominator != 32'h1) |=> intModeErr)
		else $error("integer mode setting not flagged");
	addr_err_a: assert property ((regRdEn || regWrEn) && (regAddr < 10'h10a ||
		regAddr > 10'h114) |=> regAddrErr) else $error("unmapped access not flagged");
	cover property (regWrEn && regAddr == 10'h114);
	cover property (denZeroErr);
	cover property (intModeErr);
endmodule // pll_fb_regs_monitor

bind pll_feedback_divider_regs pll_fb_regs_monitor pll_fb_regs_monitor_i (.clock, .rst_n,
	.regAddr, .regWrEn, .regWrData, .regRdEn, .regRdData, .regRdValid, .regAddrErr,
	.fixedDivisorHigh,
	.feedbackDenominator, .feedbackRemainder, .fractionTruncatePosition, .validFracBits,
	.denZeroErr, .intModeErr);

// >>> tb/pll_feedback_divider_regs_tb.sv
// Self-checking bench for the feedback divider register bank.
// Drives the byte register port directly at falling clock edges.
`timescale 1ns/1ns
`define CHK(g, e) begin checksDone++; if ((g) !== (e)) begin errors++; \
	$display("FAIL %0t got %h exp %h", $time, g, e); end end
module pll_feedback_divider_regs_tb;
	logic clock = 0, rst_n = 0, regWrEn = 0, regRdEn = 0;
	logic [9:0] regAddr = 0;
	logic [7:0] regWrData = 0, regRdData, fractionTruncatePosition;
	logic regRdValid, regAddrErr, fractionalMode, denZeroErr, truncRangeErr;
	logic intModeErr, truncBitErr, intZeroErr;
	logic [9:0] fixedDivisorHigh;
	logic [31:0] feedbackDenominator, feedbackRemainder;
	logic [5:0] validFracBits;
	logic [7:0] pt [4] = '{8'h00, 8'h09, 8'h21, 8'h22};
	int errors = 0, checksDone = 0, i;
	always #5 clock = ~clock;
	pll_feedback_divider_regs pll_feedback_divider_regs_i (.clock, .rst_n, .regAddr, .regWrEn,
		.regWrData, .regRdEn, .regRdData, .regRdValid, .regAddrErr, .fixedDivisorHigh,
		.feedbackDenominator, .feedbackRemainder, .fractionTruncatePosition, .validFracBits,
		.fractionalMode, .denZeroErr, .truncRangeErr, .intModeErr, .truncBitErr, .intZeroErr);
	// Last wait lets the registered flags settle
	task automatic wr(input logic [9:0] a, input logic [7:0] v);
		@(negedge clock);
		regWrEn = 1;
		regAddr = a;
		regWrData = v;
		@(negedge clock);
		regWrEn = 0;
		@(negedge clock);
	endtask
	task automatic rd(input logic [9:0] a, input logic [7:0] v, input logic e);
		@(negedge clock);
		regRdEn = 1;
		regAddr = a;
		@(negedge clock);
		regRdEn = 0;
		`CHK(regRdValid, 1'b1)
		`CHK(regRdData, v)
		`CHK(regAddrErr, e)
	endtask
	task stop_test;
		$display("errors %0d checks %0d", errors, checksDone);
		if (errors == 0 && checksDone > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	initial begin
		#20000;
		errors++;
		stop_test;
	end
	initial begin
		repeat (3) @(negedge clock);
		rst_n = 1;
		`CHK(validFracBits, 6'h21)
		`CHK(intZeroErr, 1'b1)
		for (i = 0; i < 11; i++) rd(10'h10a + 10'(i), i == 2 ? 8'h01 : 8'h00, 1'b0);
		for (i = 0; i < 11; i++) wr(10'h10a + 10'(i), 8'h81 + 8'(i));
		for (i = 0; i < 11; i++) rd(10'h10a + 10'(i), i == 1 ? 8'h02 : 8'h81 + 8'(i), 1'b0);
		`CHK(fixedDivisorHigh, 10'h281)
		`CHK(feedbackDenominator, 32'h86858483)
		`CHK(feedbackRemainder, 32'h8a898887)
		`CHK(fractionTruncatePosition, 8'h8b)
		`CHK(truncRangeErr, 1'b1)
		`CHK(intZeroErr, 1'b0)
		rd(10'h109, 8'h00, 1'b1);
		rd(10'h115, 8'h00, 1'b1);
		for (i = 0; i < 4; i++) begin
			wr(10'h114, pt[i]);
			`CHK(validFracBits, pt[i] > 8'h21 ? 6'h00 : 6'h21 - pt[i][5:0])
			`CHK(truncBitErr, pt[i] == 8'h21)
			`CHK(intModeErr, pt[i] == 8'h00)
			`CHK(fractionalMode, 1'b1)
		end
		for (i = 0; i < 4; i++) wr(10'h110 + 10'(i), 8'h00);
		for (i = 0; i < 4; i++) wr(10'h10c + 10'(i), i == 0 ? 8'h01 : 8'h00);
		wr(10'h114, 8'h00);
		`CHK(intModeErr, 1'b0)
		`CHK(fractionalMode, 1'b0)
		wr(10'h10c, 8'h00);
		`CHK(denZeroErr, 1'b1)
		`CHK(intModeErr, 1'b1)
		wr(10'h10b, 8'hfc);
		wr(10'h10a, 8'h01);
		`CHK(intZeroErr, 1'b1)
		`CHK(fixedDivisorHigh, 10'h001)
		rd(10'h10b, 8'h00, 1'b0);
		wr(10'h115, 8'hff);
		rd(10'h114, 8'h00, 1'b0);
		@(negedge clock);
		rst_n = 0;
		@(negedge clock);
		rst_n = 1;
		rd(10'h10c, 8'h01, 1'b0);
		`CHK(fixedDivisorHigh, 10'h000)
		`CHK(denZeroErr, 1'b0)
		`CHK(intZeroErr, 1'b1)
		stop_test;
	end
endmodule // pll_feedback_divider_regs_tb
